// ==== rtl/dsih_pkg.sv ====
// Constants and types used by the sequencer; the return stack takes its sizes as parameters.
// Assumes a single 20 MHz core clock and a synchronous active-low reset.
package dsih_pkg;

  // Program counter spans 64K instruction words
  localparam int PC_WIDTH    = 16;
  localparam int IR_WIDTH    = 32;
  localparam int STACK_DEPTH = 4;
  localparam int TIMER_WIDTH = 16;
  localparam int NUM_SRC     = 9;   // Maskable sources, priorities 2..10

  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_BASE    = 16'h0001;  // Source i -> base + i
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [31:0] IR_RESET    = 32'h0000_0000;

  // Bit positions in pending, mask and in-service vectors
  localparam int SRC_TIMER = 0;
  localparam int SRC_ZDV   = 1;
  localparam int SRC_OVF   = 2;
  localparam int SRC_UNF   = 3;
  localparam int SRC_EXT0  = 4;
  localparam int SRC_IO    = 8;

  // Frozen-state access map on the external address bus
  localparam logic [15:0] DBG_PC      = 16'h0000;
  localparam logic [15:0] DBG_TIMER   = 16'h0001;
  localparam logic [15:0] DBG_INSVC   = 16'h0002;
  localparam logic [15:0] DBG_PENDING = 16'h0003;
  localparam logic [15:0] DBG_IR      = 16'h0004;

  typedef enum logic [1:0] {
    DSIH_RUN,
    DSIH_FROZEN,
    DSIH_STEP
  } dsih_hold_type;

endpackage

// ==== rtl/dsih_return_stack.sv ====
// Return-address stack for the program sequencer.
// Assumes the owner never pushes and pops in the same cycle.
`timescale 1ns/1ps
module dsih_return_stack #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_data,
  output logic                  full,
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [CW-1:0]    count_reg;

  // Push on a full stack is dropped so older entries stay intact
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      count_reg <= '0;
    end else if (push && !full) begin
      count_reg <= count_reg + CW'(1);
    end else if (pop && count_reg != '0) begin
      count_reg <= count_reg - CW'(1);
    end
  end

  // Entry storage, no reset needed: count guards validity
  always_ff @(posedge core_clk) begin
    if (rst_n && !clear && push && !full) begin
      entry_reg[count_reg[$clog2(DEPTH)-1:0]] <= push_data;
    end
  end

  assign full     = (count_reg == CW'(DEPTH));
  assign count    = count_reg;
  assign top_data = (count_reg == '0) ? '0 :
                    entry_reg[$clog2(DEPTH)'(count_reg - CW'(1))];

endmodule

// ==== rtl/dsih_sequencer.sv ====
// Program sequencer with prioritised interrupts, return stack and halt.
// Assumes all inputs are synchronous to core_clk; events are 1-cycle
// pulses and external request pins are idle high.
//
// What this block does
// [RULE_01] Reset clears PC to zero; PC then advances by one each cycle.
// [RULE_02] PC is sixteen bits, covering 64K instruction words.
// [RULE_03] Branch or accepted interrupt loads target, pushes old PC.
// [RULE_04] Return stack holds four entries for four nesting levels.
// [RULE_05] Each cycle the internal or external program word enters IR1.
// [RULE_06] Ten sources ranked; lower priority refused while higher served.
// [RULE_07] Low reset input is priority 1, vectors to 0000.
// [RULE_08] Sixteen-bit interval counter reaching zero raises priority 2, 0001.
// [RULE_09] Floating divide by zero traps at priority 3 to 0002.
// [RULE_10] Arithmetic overflow traps at priority 4 to 0003.
// [RULE_11] Floating underflow traps at priority 5 to 0004.
// [RULE_12] Falling edge on request pins 0..3 vectors 0005..0008, priority 6..9.
// [RULE_13] Serial or parallel input data ready: priority 10 to 0009.
// [RULE_14] Hold request high freezes execution and raises hold grant.
// [RULE_15] While frozen, controller reads and writes state over pins.
// [RULE_16] Hold request low resumes instruction execution.
// [RULE_17] Each rising step pulse while frozen executes one instruction.
// [RULE_18] Non-reset sources are individually maskable; masked stays pending.
// [RULE_19] Requests accepted at boundaries; full stack keeps older entries.
`timescale 1ns/1ps
module dsih_sequencer #(
  parameter int PC_W = dsih_pkg::PC_WIDTH,
  parameter int IR_W = dsih_pkg::IR_WIDTH
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            reset_in_n,
  input  wire logic            branch_req,
  input  wire logic [PC_W-1:0] branch_target,
  input  wire logic            return_req,
  input  wire logic            ext_prog_sel,
  input  wire logic [IR_W-1:0] internal_program_memory,
  input  wire logic [IR_W-1:0] external_program_memory,
  input  wire logic            interval_run,
  input  wire logic [15:0]     interval_reload,
  input  wire logic            divide_by_zero_trap,
  input  wire logic            overflow_trap,
  input  wire logic            underflow_trap,
  input  wire logic            ext_irq_pin_zero_n,
  input  wire logic            ext_irq_pin_one_n,
  input  wire logic            ext_irq_pin_two_n,
  input  wire logic            ext_irq_pin_three_n,
  input  wire logic            serial_input_zero,
  input  wire logic            serial_input_one,
  input  wire logic            parallel_input,
  input  wire logic [8:0]      irq_mask,
  input  wire logic            hold_request,
  input  wire logic            step_pulse,
  input  wire logic [15:0]     external_address_bus,
  input  wire logic            dbg_read,
  input  wire logic            dbg_write,
  input  wire logic [31:0]     data_bus_in,
  output logic      [31:0]     data_bus_out,
  output logic                 data_bus_oe,
  output logic      [PC_W-1:0] prog_addr,
  output logic      [IR_W-1:0] first_instruction_register,
  output logic                 hold_grant,
  output logic                 irq_accept,
  output logic      [8:0]      in_service,
  output logic                 stack_dropped
);

  localparam int NS = dsih_pkg::NUM_SRC;

  dsih_pkg::dsih_hold_type state_reg, state_next;
  logic [PC_W-1:0] pc_reg;
  logic [IR_W-1:0] ir_reg;
  logic [15:0]     interval_counter;
  logic [NS-1:0]   pending_reg, in_service_reg, set_evt, clr_evt;
  logic [3:0]      ext_prev_reg, ext_now;
  logic            step_prev_reg, hold_grant_reg, accept_reg, dropped_reg;
  logic [31:0]     dbg_data_reg;
  logic            dbg_oe_reg;
  logic            exec, step_rise, accept, push, pop, stk_full, timer_hit;
  logic [3:0]      svc_limit, sel_idx;
  logic            sel_valid;
  logic [PC_W-1:0] stk_top;
  logic [2:0]      stk_count;

  // Hold control: one instruction per step edge while frozen
  assign step_rise = step_pulse && !step_prev_reg;
  assign exec      = (state_reg != dsih_pkg::DSIH_FROZEN);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dsih_pkg::DSIH_RUN: begin
        if (hold_request) state_next = dsih_pkg::DSIH_FROZEN; // see [RULE_14]
      end
      dsih_pkg::DSIH_FROZEN: begin
        if (!hold_request) begin
          state_next = dsih_pkg::DSIH_RUN;                  // see [RULE_16]
        end else if (step_rise) begin
          state_next = dsih_pkg::DSIH_STEP;                 // see [RULE_17]
        end
      end
      dsih_pkg::DSIH_STEP: begin
        state_next = hold_request ? dsih_pkg::DSIH_FROZEN
                                  : dsih_pkg::DSIH_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg      <= dsih_pkg::DSIH_RUN;
      hold_grant_reg <= 1'b0;
      step_prev_reg  <= 1'b0;
    end else begin
      state_reg      <= state_next;
      hold_grant_reg <= (state_next != dsih_pkg::DSIH_RUN); // see [RULE_14]
      step_prev_reg  <= step_pulse;
    end
  end

  // Event capture; a new event in the clearing cycle still sticks
  assign ext_now = {ext_irq_pin_three_n, ext_irq_pin_two_n,
                    ext_irq_pin_one_n, ext_irq_pin_zero_n};
  assign timer_hit = exec && interval_run && interval_counter == 16'h0001;

  always_comb begin
    set_evt = '0;
    set_evt[dsih_pkg::SRC_TIMER] = timer_hit;             // see [RULE_08]
    set_evt[dsih_pkg::SRC_ZDV]   = divide_by_zero_trap;   // see [RULE_09]
    set_evt[dsih_pkg::SRC_OVF]   = overflow_trap;         // see [RULE_10]
    set_evt[dsih_pkg::SRC_UNF]   = underflow_trap;        // see [RULE_11]
    set_evt[dsih_pkg::SRC_EXT0 +: 4] = ext_prev_reg & ~ext_now; // see [RULE_12]
    set_evt[dsih_pkg::SRC_IO] = serial_input_zero || serial_input_one
                                || parallel_input;        // see [RULE_13]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_prev_reg <= 4'hf;
      pending_reg  <= '0;
    end else begin
      ext_prev_reg <= ext_now;
      pending_reg  <= (pending_reg & ~clr_evt) | set_evt;
    end
  end

  // Highest eligible source above the level now in service
  always_comb begin
    svc_limit = 4'(NS);
    sel_valid = 1'b0;
    sel_idx   = 4'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (in_service_reg[i]) svc_limit = 4'(i);             // see [RULE_06]
    end
    for (int i = NS - 1; i >= 0; i--) begin
      if (4'(i) < svc_limit && pending_reg[i] && !irq_mask[i]) begin
        sel_valid = 1'b1;                                   // see [RULE_18]
        sel_idx   = 4'(i);
      end
    end
  end

  // Only sequential-flow cycles act as acceptance boundaries
  assign accept = exec && reset_in_n && sel_valid && !branch_req
                  && !return_req;                           // see [RULE_19]
  assign clr_evt = (accept ? (NS'(1) << sel_idx) : '0)
                   | (exec && !reset_in_n ? {NS{1'b1}} : '0);
  assign push = exec && reset_in_n && (accept || branch_req);
  assign pop  = exec && reset_in_n && !accept && !branch_req && return_req;

  // Program counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc_reg <= dsih_pkg::PC_RESET;                         // see [RULE_01]
    end else if (exec) begin
      if (!reset_in_n) begin
        pc_reg <= dsih_pkg::VEC_RESET;                      // see [RULE_07]
      end else if (accept) begin
        pc_reg <= dsih_pkg::VEC_BASE + 16'(sel_idx);        // see [RULE_03]
      end else if (branch_req) begin
        pc_reg <= branch_target;                            // see [RULE_03]
      end else if (return_req) begin
        pc_reg <= stk_top;
      end else begin
        pc_reg <= pc_reg + 16'h0001;                        // see [RULE_02]
      end
    end else if (dbg_write && external_address_bus == dsih_pkg::DBG_PC) begin
      pc_reg <= data_bus_in[PC_W-1:0];                      // see [RULE_15]
    end
  end

  // Service nesting; a return retires the most recent level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_service_reg <= '0;
      accept_reg     <= 1'b0;
      dropped_reg    <= 1'b0;
    end else begin
      accept_reg <= accept;
      if (exec && !reset_in_n) begin
        in_service_reg <= '0;
        dropped_reg    <= 1'b0;
      end else if (accept) begin
        in_service_reg <= in_service_reg | (NS'(1) << sel_idx);
      end else if (pop) begin
        in_service_reg <= in_service_reg & (in_service_reg - NS'(1));
      end
      if (push && stk_full) dropped_reg <= 1'b1;            // see [RULE_19]
    end
  end

  // Instruction fetch latch, frozen with the core
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ir_reg <= dsih_pkg::IR_RESET;
    end else if (exec) begin
      ir_reg <= ext_prog_sel ? external_program_memory
                             : internal_program_memory;    // see [RULE_05]
    end
  end

  // Interval counter reloads after reaching zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      interval_counter <= dsih_pkg::TIMER_RESET;
    end else if (!exec) begin
      if (dbg_write && external_address_bus == dsih_pkg::DBG_TIMER)
        interval_counter <= data_bus_in[15:0];             // see [RULE_15]
    end else if (interval_run) begin
      interval_counter <= (interval_counter == 16'h0000) ? interval_reload
                          : interval_counter - 16'h0001;   // see [RULE_08]
    end
  end

  // Frozen-state readback, driven only while the grant is up
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dbg_data_reg <= 32'h0000_0000;
      dbg_oe_reg   <= 1'b0;
    end else begin
      dbg_oe_reg <= hold_grant_reg && dbg_read;            // see [RULE_15]
      unique case (external_address_bus)
        dsih_pkg::DBG_PC:      dbg_data_reg <= 32'(pc_reg);
        dsih_pkg::DBG_TIMER:   dbg_data_reg <= 32'(interval_counter);
        dsih_pkg::DBG_INSVC:   dbg_data_reg <= 32'(in_service_reg);
        dsih_pkg::DBG_PENDING: dbg_data_reg <= 32'(pending_reg);
        dsih_pkg::DBG_IR:      dbg_data_reg <= 32'(ir_reg);
        default:               dbg_data_reg <= 32'h0000_0000;
      endcase
    end
  end

  dsih_return_stack #(
    .DEPTH (dsih_pkg::STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_return_stack (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clear     (exec && !reset_in_n),
    .push      (push),                                      // see [RULE_04]
    .pop       (pop),
    .push_data (pc_reg),
    .top_data  (stk_top),
    .full      (stk_full),
    .count     (stk_count)
  );

  assign data_bus_out               = dbg_data_reg;
  assign data_bus_oe                = dbg_oe_reg;
  assign prog_addr                  = pc_reg;
  assign first_instruction_register = ir_reg;
  assign hold_grant                 = hold_grant_reg;
  assign irq_accept                 = accept_reg;
  assign in_service                 = in_service_reg;
  assign stack_dropped              = dropped_reg;

  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence plain_step_s;
    exec && reset_in_n && !accept && !branch_req && !return_req;
  endsequence
  sequence frozen_idle_s;
    state_reg == dsih_pkg::DSIH_FROZEN && hold_request && !step_rise
    && !dbg_write;
  endsequence

  pc_advance_a: assert property (plain_step_s |=> pc_reg == $past(pc_reg)
    + 16'h0001) else $error("pc did not advance"); // see [RULE_01]
  reset_vec_a: assert property (exec && !reset_in_n |=> pc_reg == 16'h0000
    && stk_count == 3'd0) else $error("reset vector wrong"); // see [RULE_07]
  irq_vector_a: assert property (accept |=> pc_reg == 16'h0001
    + 16'($past(sel_idx)) && irq_accept) else $error("bad vector"); // see [RULE_03]
  push_old_a: assert property (push && !stk_full |=> stk_top ==
    $past(pc_reg)) else $error("old pc not stacked"); // see [RULE_03]
  stack_depth_a: assert property (stk_count <= 3'd4)
    else $error("stack over depth"); // see [RULE_04]
  ir_capture_a: assert property (exec |=> ir_reg == $past(ext_prog_sel ?
    external_program_memory : internal_program_memory))
    else $error("ir1 not loaded"); // see [RULE_05]
  prio_refuse_a: assert property (accept |-> sel_idx < svc_limit
    && !irq_mask[sel_idx]) else $error("refused source taken"); // see [RULE_06]
  ext_pend_a: assert property (ext_prev_reg[0] && !ext_irq_pin_zero_n
    |=> pending_reg[dsih_pkg::SRC_EXT0] || $past(accept))
    else $error("edge lost"); // see [RULE_12]
  hold_grant_a: assert property (hold_request && hold_request[*1] ##1
    hold_request |-> hold_grant) else $error("no grant"); // see [RULE_14]
  resume_a: assert property (!hold_request ##1 !hold_request |-> !hold_grant
    && exec) else $error("no resume"); // see [RULE_16]
  step_once_a: assert property (state_reg == dsih_pkg::DSIH_FROZEN
    && hold_request && step_rise ##1 hold_request |=> pc_reg != 16'hffff
    && state_reg == dsih_pkg::DSIH_FROZEN) else $error("step misbehaved"); // see [RULE_17]
  frozen_pc_a: assert property (frozen_idle_s |=> pc_reg == $past(pc_reg))
    else $error("pc moved while frozen"); // see [RULE_17]
  full_keep_a: assert property (push && stk_full |=> stk_top ==
    $past(stk_top) && stack_dropped) else $error("stack corrupted"); // see [RULE_19]

endmodule

// ==== tb/dsih_partner.sv ====
// Far-side model: external request pins and the halt/debug host.
// Assumes its tasks are called just after a falling core_clk edge.
`timescale 1ns/1ps
module dsih_partner (
  input  wire logic        core_clk,
  input  wire logic [31:0] bus_wire,
  output logic      [3:0]  irq_pin_n,
  output logic             hold_request,
  output logic             step_pulse,
  output logic      [15:0] dbg_addr,
  output logic             dbg_read,
  output logic             dbg_write,
  output logic      [31:0] host_data
);
  // Pins idle high; a released host shows an inverted pattern
  initial begin
    irq_pin_n = 4'hf;
    hold_request = 1'b0;
    step_pulse = 1'b0;
    dbg_addr = 16'hffff;
    dbg_read = 1'b0;
    dbg_write = 1'b0;
    host_data = 32'h5a5a_a5a5;
  end

  // One cycle low after idle high gives a clean falling pulse
  task automatic fire(input int i);
    irq_pin_n[i] = 1'b0;
    @(negedge core_clk);
    irq_pin_n[i] = 1'b1;
  endtask

  // Freeze or resume; a level held until the host changes its mind
  task automatic hold(input logic v);
    hold_request = v;
  endtask

  // Step low again afterwards so the next rising edge is distinct
  task automatic step();
    step_pulse = 1'b1;
    @(negedge core_clk);
    step_pulse = 1'b0;
    @(negedge core_clk);
  endtask

  // Read: data appears one cycle after the strobe is taken
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    dbg_addr = a;
    dbg_read = 1'b1;
    @(negedge core_clk);
    d = bus_wire;
    dbg_read = 1'b0;
    dbg_addr = ~a;
    // Let the readback enable drop before the host drives the lines again
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    dbg_addr = a;
    host_data = d;
    dbg_write = 1'b1;
    @(negedge core_clk);
    dbg_write = 1'b0;
    host_data = ~d;
    dbg_addr = ~a;
    @(negedge core_clk);
  endtask
endmodule

// ==== tb/dsih_sequencer_tb.sv ====
// Self-checking bench: flow, return stack, interrupts, halt and step.
// Assumes the far-side model drives request pins and the debug host.
`timescale 1ns/1ps
module dsih_sequencer_tb;
  logic        core_clk, rst_n, reset_in_n, branch_req, return_req;
  logic        ext_prog_sel, interval_run, divide_by_zero_trap;
  logic        overflow_trap, underflow_trap, serial_input_zero;
  logic        serial_input_one, parallel_input, hold_request, step_pulse;
  logic        dbg_read, dbg_write, data_bus_oe, hold_grant, irq_accept;
  logic        stack_dropped, ok, sel;
  logic [3:0]  irq_pin_n;
  logic [8:0]  irq_mask, in_service;
  logic [15:0] branch_target, interval_reload, external_address_bus;
  logic [15:0] prog_addr, prv, p, p1, p2;
  logic [15:0] pushed [4];
  logic [31:0] internal_program_memory, external_program_memory;
  logic [31:0] first_instruction_register, data_bus_out, host_data;
  logic [31:0] bus_wire, d, w, wi, we;
  integer      seed = 32'ha78f0eed;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // Host drives the data lines only while the sequencer does not
  assign bus_wire = data_bus_oe ? data_bus_out : host_data;

  dsih_sequencer u_dsih_sequencer (.core_clk, .rst_n, .reset_in_n,
    .branch_req, .branch_target, .return_req, .ext_prog_sel,
    .internal_program_memory, .external_program_memory, .interval_run,
    .interval_reload, .divide_by_zero_trap, .overflow_trap,
    .underflow_trap, .ext_irq_pin_zero_n(irq_pin_n[0]),
    .ext_irq_pin_one_n(irq_pin_n[1]), .ext_irq_pin_two_n(irq_pin_n[2]),
    .ext_irq_pin_three_n(irq_pin_n[3]), .serial_input_zero,
    .serial_input_one, .parallel_input, .irq_mask, .hold_request,
    .step_pulse, .external_address_bus, .dbg_read, .dbg_write,
    .data_bus_in(bus_wire), .data_bus_out, .data_bus_oe, .prog_addr,
    .first_instruction_register, .hold_grant, .irq_accept, .in_service,
    .stack_dropped);

  dsih_partner u_dsih_partner (.core_clk, .bus_wire, .irq_pin_n,
    .hold_request, .step_pulse, .dbg_addr(external_address_bus),
    .dbg_read, .dbg_write, .host_data);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk16(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Bounded wait for an acceptance; prv keeps the pc just before it
  task automatic wait_acc(input int n);
    ok = 1'b0;
    for (int i = 0; i < n; i++) begin
      prv = prog_addr;
      tick(1);
      if (irq_accept === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask

  task automatic expect_irq(input int i);
    wait_acc(12);
    chk1("accepted", 1'b1, ok);
    chk16("vector", 16'h0001 + 16'(i), prog_addr);
    chk1("in service", 1'b1, in_service[i]);
  endtask

  // Raise source i; pulses last one cycle, the timer just runs
  task automatic fire_src(input int i);
    case (i)
      0: interval_run = 1'b1;
      1: divide_by_zero_trap = 1'b1;
      2: overflow_trap = 1'b1;
      3: underflow_trap = 1'b1;
      8: {parallel_input, serial_input_one, serial_input_zero} =
           3'h1 << ($unsigned($random(seed)) % 3);
      default: u_dsih_partner.fire(i - 4);
    endcase
    if (i inside {[1:3], 8}) begin
      tick(1);
      divide_by_zero_trap = 1'b0;
      overflow_trap = 1'b0;
      underflow_trap = 1'b0;
      {parallel_input, serial_input_one, serial_input_zero} = 3'h0;
    end
  endtask

  // Chained returns keep the strobe up instead of dropping and re-raising it
  task automatic do_ret(input logic [15:0] e, input logic more);
    return_req = 1'b1;
    tick(1);
    if (!more) return_req = 1'b0;
    chk16("return pc", e, prog_addr);
  endtask

  // Hang guard: a run that never ends is a failure
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("[ERR] run expected end seen timeout");
    results();
  end

  initial begin
    {rst_n, branch_req, return_req, ext_prog_sel, interval_run} = 5'h0;
    {divide_by_zero_trap, overflow_trap, underflow_trap} = 3'h0;
    {serial_input_zero, serial_input_one, parallel_input} = 3'h0;
    reset_in_n = 1'b1;
    branch_target = 16'h0000;
    interval_reload = 16'h0003;
    irq_mask = 9'h000;
    internal_program_memory = 32'h0000_0000;
    external_program_memory = 32'h0000_0000;
    tick(4);
    chk16("pc at reset", 16'h0000, prog_addr);
    chk32("ir at reset", 32'h0000_0000, first_instruction_register);
    rst_n = 1'b1;
    tick(1);
    // Random words and source select, pc counting every cycle
    p = prog_addr;
    for (int k = 1; k <= 40; k++) begin
      wi = $random(seed);
      we = $random(seed);
      sel = wi[0] ^ we[3];
      internal_program_memory = wi;
      external_program_memory = we;
      ext_prog_sel = sel;
      tick(1);
      chk32("ir", sel ? we : wi, first_instruction_register);
      chk16("pc count", p + 16'(k), prog_addr);
    end
    branch_req = 1'b1;
    branch_target = 16'hffff;
    tick(1);
    branch_req = 1'b0;
    tick(1);
    chk16("pc wrap", 16'h0000, prog_addr);
    // The wrap branch stacked its return address; empty the stack again
    do_ret(p + 16'd40, 1'b0);
    $display("test flow done");
    // Five nested calls on a four-deep stack, back to back
    for (int k = 0; k < 5; k++) begin
      if (k < 4) pushed[k] = prog_addr;
      w = $random(seed);
      branch_req = 1'b1;
      branch_target = w[15:0];
      tick(1);
      chk16("branch pc", w[15:0], prog_addr);
    end
    branch_req = 1'b0;
    chk1("stack dropped", 1'b1, stack_dropped);
    for (int k = 3; k >= 0; k--) do_ret(pushed[k], k != 0);
    $display("test stack done");
    // Every maskable source once, each with its own vector
    for (int i = 0; i < 9; i++) begin
      fire_src(i);
      expect_irq(i);
      interval_run = 1'b0;
      do_ret(prv, 1'b0);
      chk16("service clear", 16'h0000, {7'h00, in_service});
    end
    $display("test sources done");
    // Lower refused under higher, higher nests, lower follows later
    fire_src(2);
    expect_irq(2);
    p2 = prv;
    fire_src(3);
    wait_acc(6);
    chk1("lower refused", 1'b0, ok);
    fire_src(1);
    expect_irq(1);
    p1 = prv;
    do_ret(p1, 1'b1);
    do_ret(p2, 1'b0);
    expect_irq(3);
    do_ret(prv, 1'b0);
    // Masked request waits until unmasked
    irq_mask = 9'h004;
    fire_src(2);
    wait_acc(6);
    chk1("masked refused", 1'b0, ok);
    irq_mask = 9'h000;
    expect_irq(2);
    $display("test priority done");
    // Reset pin during service clears pc, pending, service levels, stack and drop flag
    reset_in_n = 1'b0;
    tick(1);
    reset_in_n = 1'b1;
    chk16("pin reset pc", 16'h0000, prog_addr);
    chk16("pin reset svc", 16'h0000, {7'h00, in_service});
    chk1("pin reset drop", 1'b0, stack_dropped);
    $display("test reset pin done");
    // Halt, debug access, single step, resume
    u_dsih_partner.rd(16'h0000, d);
    chk1("oe running", 1'b0, data_bus_oe);
    u_dsih_partner.hold(1'b1);
    for (int i = 0; i < 4 && hold_grant !== 1'b1; i++) tick(1);
    chk1("grant", 1'b1, hold_grant);
    p = prog_addr;
    tick(5);
    chk16("frozen pc", p, prog_addr);
    u_dsih_partner.rd(16'h0000, d);
    chk16("read pc", p, d[15:0]);
    w = $random(seed);
    u_dsih_partner.wr(16'h0000, w);
    u_dsih_partner.rd(16'h0000, d);
    chk16("written pc", w[15:0], d[15:0]);
    u_dsih_partner.step();
    tick(3);
    chk16("stepped pc", w[15:0] + 16'h0001, prog_addr);
    chk1("grant in step", 1'b1, hold_grant);
    u_dsih_partner.hold(1'b0);
    tick(2);
    chk1("grant off", 1'b0, hold_grant);
    p = prog_addr;
    tick(1);
    chk16("resumed pc", p + 16'h0001, prog_addr);
    $display("test halt done");
    results();
  end
endmodule
